// ===== src/etc_timer.v
// eight-bit timer/counter with shared prescaler behind a classic wishbone slave
`include "etc_defs.vh"
////////////////////////////////////////////////////////////////////////////////
module etc_timer
(
  input  wire        CLK,
  input  wire        NRST,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [9:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire        EXTERNAL_COUNT_PIN,
  output reg         OVERFLOW_IRQ,
  output reg         WATCHDOG_TICK,
  output reg         WATCHDOG_CLEAR
);
////////////////////////////////////////////////////////////////////////////////
// registers
  reg  [7:0] count_value_r;
  reg  [7:0] interrupt_control_r;
  reg  [7:0] option_settings_r;
  reg  [7:0] port_a_direction_r;
  reg        sleep_r;
  reg  [1:0] hold_r;
  reg        pin_s1_r;
  reg        pin_s2_r;
  reg        samp_r;
  reg        samp_d_r;
  reg        ripple_r;
  reg        prev_pin_r;
  reg        q4_d_r;
  reg  [7:0] count_nxt;
  reg        flag_set;
  wire       q2;
  wire       q4;
  wire       pre_out;
  wire       wr_stb;
  wire       rd_stb;
  wire       wr_count;
  wire       wr_intctl;
  wire       wr_option;
  wire       wr_misc;
  wire       clock_source_select;
  wire       edge_select;
  wire       prescaler_assign;
  wire [2:0] prescale_field;
  wire       pin_edge;
  wire       pre_tick;
  wire       ext_event;
  wire       src_event;
  wire       cnt_event;

  assign clock_source_select = option_settings_r[`ETC_OPT_CS];
  assign edge_select         = option_settings_r[`ETC_OPT_SE];
  assign prescaler_assign    = option_settings_r[`ETC_OPT_PSA];
  assign prescale_field      = option_settings_r[`ETC_OPT_PS_MSB:0];

////////////////////////////////////////////////////////////////////////////////
// address decode, used for reads and writes
  function hit;
    input [9:0] adr;
    input [9:0] want;
    begin
      hit = (adr == want);
    end
  endfunction

  // single-cycle answer; the ack low check gives the one idle cycle after each ack
  assign wr_stb    = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0];
  assign rd_stb    = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;
  assign wr_count  = wr_stb && hit(WB_ADR_I, `ETC_ADR_COUNT);
  assign wr_intctl = wr_stb && hit(WB_ADR_I, `ETC_ADR_INTCTL);
  assign wr_option = wr_stb && hit(WB_ADR_I, `ETC_ADR_OPTION);
  assign wr_misc   = wr_stb && hit(WB_ADR_I, `ETC_ADR_MISC);

////////////////////////////////////////////////////////////////////////////////
// instruction cycle phases
  etc_phase u_phase
  (
    .clk  (CLK),
    .nrst (NRST),
    .run  (!sleep_r),
    .q2   (q2),
    .q4   (q4)
  );

////////////////////////////////////////////////////////////////////////////////
// external pin path
  // pin crosses into the clock domain through two flops first
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      pin_s1_r   <= 1'b0;
      pin_s2_r   <= 1'b0;
      prev_pin_r <= 1'b0;
    end
    else
    begin
      pin_s1_r   <= EXTERNAL_COUNT_PIN;
      pin_s2_r   <= pin_s1_r;
      prev_pin_r <= pin_s2_r;
    end
  end

  // selected edge; set edge_select means falling
  assign pin_edge = edge_select ? (prev_pin_r && !pin_s2_r) : (!prev_pin_r && pin_s2_r);

  // toggle stage keeps the prescaled output symmetrical; keeps rippling while sleeping
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      ripple_r <= 1'b0;
    else if (wr_count && !prescaler_assign)
      ripple_r <= 1'b0;
    else if (pre_out && clock_source_select && !prescaler_assign)
      ripple_r <= !ripple_r;
  end

  // sample prescaler output (or the bare pin) on q2 and q4
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      samp_r   <= 1'b0;
      samp_d_r <= 1'b0;
    end
    else if (q2 || q4)
    begin
      samp_r   <= prescaler_assign ? pin_s2_r : ripple_r;
      samp_d_r <= samp_r;
    end
  end
  // each pair of successive q2/q4 samples is compared once, so no edge falls between two looks
  // with prescaling the toggle changes once per ratio selected edges, so any change is one count
  assign ext_event = (q2 || q4)
                     && (prescaler_assign ? (edge_select ? (samp_d_r && !samp_r) : (!samp_d_r && samp_r))
                                          : (samp_r != samp_d_r));

////////////////////////////////////////////////////////////////////////////////
// shared prescaler
  // counter-owned: internal cycles or pin edges; watchdog-owned: one tick per cycle
  assign pre_tick = prescaler_assign ? q4 : (clock_source_select ? pin_edge : q4);

  etc_prescale #(.WIDTH(8)) u_pre
  (
    .clk       (CLK),
    .nrst      (NRST),
    .tick      (pre_tick),
    .clr       ((wr_count && !prescaler_assign) || wr_option),
    .sel       (prescale_field),
    .out_pulse (pre_out)
  );

  // both prescaled paths advance once per prescaler output pulse
  assign src_event = clock_source_select ? ext_event
                                         : (prescaler_assign ? q4 : pre_out);
  assign cnt_event = src_event && !sleep_r && (hold_r == 2'h0);

////////////////////////////////////////////////////////////////////////////////
// count and flag
  always @*
  begin
    count_nxt = count_value_r;
    flag_set  = 1'b0;
    if (wr_count)
      count_nxt = WB_DAT_I[7:0];
    else if (cnt_event)
    begin
      count_nxt = count_value_r + 8'h01;
      flag_set  = (count_value_r == 8'hFF);
    end
  end

  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      count_value_r       <= `ETC_COUNT_RST;
      hold_r              <= 2'h0;
      interrupt_control_r <= `ETC_INTCTL_RST;
      option_settings_r   <= `ETC_OPTION_RST;
      port_a_direction_r  <= `ETC_PORTADIR_RST;
      sleep_r             <= 1'b0;
    end
    else
    begin
      count_value_r <= count_nxt;
      if (wr_count)
        hold_r <= `ETC_WRITE_HOLD;
      else if (q4 && hold_r != 2'h0)
        hold_r <= hold_r - 2'h1;
      if (wr_intctl)
        interrupt_control_r <= WB_DAT_I[7:0];
      // hardware set beats a software clear in the same cycle
      if (flag_set)
        interrupt_control_r[`ETC_INT_OVF_FLAG] <= 1'b1;
      if (wr_option)
        option_settings_r <= WB_DAT_I[7:0];
      if (wr_stb && hit(WB_ADR_I, `ETC_ADR_PORTADIR))
        port_a_direction_r <= WB_DAT_I[7:0];
      if (wr_misc)
        sleep_r <= WB_DAT_I[`ETC_MISC_SLEEP];
    end
  end

////////////////////////////////////////////////////////////////////////////////
// outputs and bus answer
  always @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      WB_ACK_O       <= 1'b0;
      WB_DAT_O       <= 32'h00000000;
      OVERFLOW_IRQ   <= 1'b0;
      WATCHDOG_TICK  <= 1'b0;
      WATCHDOG_CLEAR <= 1'b0;
      q4_d_r         <= 1'b0;
    end
    else
    begin
      WB_ACK_O <= WB_CYC_I && WB_STB_I && !WB_ACK_O;
      WB_DAT_O <= 32'h00000000;
      // prescaler count has no address; unmapped reads give zero
      if (rd_stb)
      begin
        if (hit(WB_ADR_I, `ETC_ADR_COUNT))
          WB_DAT_O <= {24'h000000, count_value_r};
        else if (hit(WB_ADR_I, `ETC_ADR_INTCTL))
          WB_DAT_O <= {24'h000000, interrupt_control_r};
        else if (hit(WB_ADR_I, `ETC_ADR_OPTION))
          WB_DAT_O <= {24'h000000, option_settings_r};
        else if (hit(WB_ADR_I, `ETC_ADR_PORTADIR))
          WB_DAT_O <= {24'h000000, port_a_direction_r};
        else if (hit(WB_ADR_I, `ETC_ADR_MISC))
          WB_DAT_O <= {31'h00000000, sleep_r};
      end
      OVERFLOW_IRQ <= interrupt_control_r[`ETC_INT_OVF_FLAG]
                      && interrupt_control_r[`ETC_INT_OVF_EN];
      // delayed q4 shares the phase of the prescaler output, so an owner change never squeezes two ticks
      q4_d_r         <= q4;
      WATCHDOG_TICK  <= prescaler_assign ? pre_out : q4_d_r;
      WATCHDOG_CLEAR <= wr_misc && WB_DAT_I[`ETC_MISC_WDT_CLR];
    end
  end
endmodule // etc_timer

// ===== src/etc_defs.vh
// register map, field positions, reset values and timing of the eight-bit timer/counter
`ifndef ETC_DEFS_VH
`define ETC_DEFS_VH
// byte addresses (word index times four)
`define ETC_IDX_COUNT      8'h01
`define ETC_IDX_INTCTL     8'h0B
`define ETC_IDX_OPTION     8'h81
`define ETC_IDX_PORTADIR   8'h85
`define ETC_IDX_MISC       8'hC0
`define ETC_ADR_COUNT      10'h004
`define ETC_ADR_INTCTL     10'h02C
`define ETC_ADR_OPTION     10'h204
`define ETC_ADR_PORTADIR   10'h214
`define ETC_ADR_MISC       10'h300
// option register fields
`define ETC_OPT_CS         5
`define ETC_OPT_SE         4
`define ETC_OPT_PSA        3
`define ETC_OPT_PS_MSB     2
// interrupt control fields
`define ETC_INT_OVF_EN     5
`define ETC_INT_OVF_FLAG   2
// misc register fields (sleep control, watchdog clear request)
`define ETC_MISC_SLEEP     0
`define ETC_MISC_WDT_CLR   1
// reset values
`define ETC_OPTION_RST     8'hFF
`define ETC_PORTADIR_RST   8'hFF
`define ETC_INTCTL_RST     8'h00
`define ETC_COUNT_RST      8'h00
// instruction cycle is four oscillator periods
`define ETC_PHASES         4
`define ETC_WRITE_HOLD     2'h2
`endif

// ===== src/etc_phase.v
// four-phase instruction cycle generator: q2 and q4 strobes
`include "etc_defs.vh"
module etc_phase
(
  input  wire       clk,
  input  wire       nrst,
  input  wire       run,
  output reg        q2,
  output reg        q4
);
  reg [1:0] ph_r;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ph_r <= 2'h0;
      q2   <= 1'b0;
      q4   <= 1'b0;
    end
    else
    begin
      // phases stop with the core clock during sleep
      if (run)
        ph_r <= ph_r + 2'h1;
      q2 <= run && (ph_r == 2'h0);
      q4 <= run && (ph_r == 2'h2);
    end
  end
endmodule // etc_phase

// ===== src/etc_prescale.v
// shared prescaler: divides counter events, or watchdog ticks, by 2 to 256
`include "etc_defs.vh"
module etc_prescale
#(
  parameter WIDTH = 8
)
(
  input  wire       clk,
  input  wire       nrst,
  input  wire       tick,
  input  wire       clr,
  input  wire [2:0] sel,
  output reg        out_pulse
);
  reg [WIDTH-1:0] cnt_r;
  wire [WIDTH-1:0] cnt_nxt;
  wire [WIDTH-1:0] mask;
  assign cnt_nxt = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
  // field 0 gives 1:2, field 7 gives 1:256
  // shift amount is four bits wide so that field 7 reaches a shift of 8 instead of wrapping to 0
  assign mask = (({{(WIDTH-1){1'b0}}, 1'b1}) << ({1'b0, sel} + 4'h1)) - {{(WIDTH-1){1'b0}}, 1'b1};
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r     <= {WIDTH{1'b0}};
      out_pulse <= 1'b0;
    end
    else if (clr)
    begin
      cnt_r     <= {WIDTH{1'b0}};
      out_pulse <= 1'b0;
    end
    else
    begin
      out_pulse <= tick && ((cnt_nxt & mask) == {WIDTH{1'b0}});
      if (tick)
        cnt_r <= cnt_nxt;
    end
  end
endmodule // etc_prescale

// ===== verif/etc_chk_sva.sv
// bus, watchdog and overflow checker of the timer/counter
`include "etc_defs.vh"
module etc_chk
(
  input wire        CLK,
  input wire        NRST,
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_WE_I,
  input wire [9:0]  WB_ADR_I,
  input wire [3:0]  WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire        WB_ACK_O,
  input wire        OVERFLOW_IRQ,
  input wire        WATCHDOG_TICK,
  input wire        WATCHDOG_CLEAR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  wire tk = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wr = tk & WB_WE_I & WB_SEL_I[0];
  ////////////////////////////////////////////////////////////////////////////////
  a_ack_follows: assert property (tk |=> WB_ACK_O) else $error("ack missing after request");
  a_ack_cause: assert property (WB_ACK_O |-> $past(tk) ##1 !WB_ACK_O) else $error("ack without request");
  a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data outside ack");
  a_dat_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0) else $error("upper read bits set");
  a_wdc_pulse: assert property (wr && WB_ADR_I == `ETC_ADR_MISC && WB_DAT_I[1] |=> WATCHDOG_CLEAR)
    else $error("watchdog clear missing");
  a_wdc_cause: assert property (WATCHDOG_CLEAR |-> $past(wr && WB_ADR_I == `ETC_ADR_MISC))
    else $error("watchdog clear unasked");
  a_irq_mask: assert property (wr && WB_ADR_I == `ETC_ADR_INTCTL && !WB_DAT_I[5] |-> ##2 !OVERFLOW_IRQ)
    else $error("masked overflow request");
  a_irq_hold: assert property (OVERFLOW_IRQ && !(WB_CYC_I && WB_WE_I) && !$past(WB_CYC_I && WB_WE_I)
    |=> OVERFLOW_IRQ) else $error("overflow request dropped");
  a_tick_space: assert property (WATCHDOG_TICK |=> !WATCHDOG_TICK [*3]) else $error("tick too often");
  c_misc: cover property (wr && WB_ADR_I == `ETC_ADR_MISC);
  c_irq: cover property ($rose(OVERFLOW_IRQ));
  c_clr: cover property (WATCHDOG_CLEAR);
endmodule // etc_chk
bind etc_timer etc_chk u_chk (.*);

// ===== verif/etc_src.sv
// external count source driving the count pin
module etc_src
(
  input  wire  clk,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b0;
  task automatic park();
    @(posedge clk);
    pin <= 1'b0;
  endtask
  // n rising edges, pin left high so the two edge counts differ by one
  task automatic burst(input int n, input int h);
    for (int i = 0; i < n; i++)
    begin
      pin <= 1'b1;
      repeat (h) @(posedge clk);
      if (i < n - 1)
        pin <= 1'b0;
      repeat (h) @(posedge clk);
    end
  endtask
endmodule // etc_src

// ===== verif/etc_timer_tb.sv
// self-checking bench of the eight-bit timer/counter
`include "etc_defs.vh"
module etc_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        nrst;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat_i;
  wire  [31:0] dat_o;
  wire         ack;
  wire         pin;
  wire         irq;
  wire         wdt;
  wire         wdc;
  int          err_count;
  int          cmp_count;
  int          seed;
  int          now = 0;
  int          tw;
  int          t0;
  int          n;
  int          ticks = 0;
  int          seen = 0;
  logic [7:0]  q;
  logic [7:0]  s;
  etc_timer dut
  (
    .CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .EXTERNAL_COUNT_PIN(pin),
    .OVERFLOW_IRQ(irq), .WATCHDOG_TICK(wdt), .WATCHDOG_CLEAR(wdc)
  );
  etc_src src (.clk(clk), .pin(pin));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    now <= now + 1;
    if (wdt === 1'b1)
      ticks <= ticks + 1;
    if (wdc === 1'b1)
      seen <= 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_i <= {24'h0, d};
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 40);
    q = dat_o[7:0];
    tw = now;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 40)
    begin
      err_count++;
      $display("Error %0t: no ack", $time);
      conclude();
    end
  endtask
  task automatic chk(input logic [7:0] g, input int lo, input int hi);
    cmp_count++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      err_count++;
      $display("Error %0t: got %h want %0d..%0d", $time, g, lo, hi);
    end
  endtask
  // increments expected over d clocks at ratio r; phase alignment leaves one count of slack
  function automatic int tcnt(input int d, input int r);
    return d / (4 * r);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {nrst, cyc, stb, we, adr, dat_i} = 0;
    sel = 4'hF;
    seed = 32'h80C34A41;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    wb(0, `ETC_ADR_OPTION, 0); chk(q, 8'hFF, 8'hFF);
    wb(0, `ETC_ADR_INTCTL, 0); chk(q, 0, 0);
    wb(0, `ETC_ADR_PORTADIR, 0); chk(q, 8'hFF, 8'hFF);
    wb(1, 10'h3FC, 8'h5A);
    wb(0, 10'h3FC, 0); chk(q, 0, 0);
    $display("reset and map test done");
    wb(1, `ETC_ADR_OPTION, 8'hC8);
    wb(0, `ETC_ADR_OPTION, 0); chk(q, 8'hC8, 8'hC8);
    s = 8'h10 + ($random(seed) & 8'h3F);
    wb(1, `ETC_ADR_COUNT, s);
    t0 = tw;
    repeat (40 + ($random(seed) & 31)) @(posedge clk);
    wb(0, `ETC_ADR_COUNT, 0); chk(q, s + tcnt(tw - t0, 1) - 3, s + tcnt(tw - t0, 1) - 1);
    wb(1, `ETC_ADR_MISC, 8'h01);
    wb(0, `ETC_ADR_COUNT, 0);
    s = q;
    repeat (200) @(posedge clk);
    wb(0, `ETC_ADR_COUNT, 0); chk(q, s, s);
    wb(1, `ETC_ADR_MISC, 8'h00);
    $display("timer mode test done");
    wb(1, `ETC_ADR_INTCTL, 8'h20);
    wb(1, `ETC_ADR_COUNT, 8'hFD);
    repeat (40) @(posedge clk);
    wb(0, `ETC_ADR_INTCTL, 0); chk(q, 8'h24, 8'h24);
    chk({7'h0, irq}, 1, 1);
    wb(0, `ETC_ADR_COUNT, 0); chk(q, 1, 12);
    wb(1, `ETC_ADR_INTCTL, 8'h04);
    wb(0, `ETC_ADR_INTCTL, 0); chk(q, 8'h04, 8'h04);
    chk({7'h0, irq}, 0, 0);
    wb(1, `ETC_ADR_INTCTL, 8'h00);
    wb(0, `ETC_ADR_INTCTL, 0); chk(q, 0, 0);
    // masked overflow: flag still sets, request stays low
    wb(1, `ETC_ADR_COUNT, 8'hFE);
    repeat (40) @(posedge clk);
    wb(0, `ETC_ADR_INTCTL, 0); chk(q, 8'h04, 8'h04);
    chk({7'h0, irq}, 0, 0);
    $display("overflow test done");
    for (int f = 0; f < 8; f++)
    begin
      wb(1, `ETC_ADR_OPTION, f);
      wb(1, `ETC_ADR_COUNT, 8'h00);
      t0 = tw;
      n = ticks;
      repeat (12 << (f + 1)) @(posedge clk);
      wb(0, `ETC_ADR_COUNT, 0); chk(q, tcnt(tw - t0, 1 << (f + 1)) - 1, tcnt(tw - t0, 1 << (f + 1)));
      if (f == 0)
        chk(ticks - n, tcnt(tw - t0, 1) - 1, tcnt(tw - t0, 1) + 1);
    end
    $display("prescaler test done");
    for (int e = 0; e < 3; e++)
    begin
      src.park();
      repeat (48) @(posedge clk);
      wb(1, `ETC_ADR_OPTION, e == 2 ? 8'h21 : 8'h28 | (e << 4));
      wb(1, `ETC_ADR_COUNT, 8'h00);
      n = e == 2 ? 32 : 5 + ($random(seed) & 7);
      // let the two blocked cycles after the count write pass before the first edge
      repeat (16) @(posedge clk);
      src.burst(n, 16);
      repeat (48) @(posedge clk);
      wb(0, `ETC_ADR_COUNT, 0);
      if (e < 2)
        chk(q, n - e, n - e);
      else
        chk(q, 4, 9);
    end
    $display("counter mode test done");
    wb(1, `ETC_ADR_MISC, 8'h02);
    repeat (2) @(posedge clk);
    chk(seen[7:0], 1, 1);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    wb(0, `ETC_ADR_OPTION, 0); chk(q, 8'hFF, 8'hFF);
    $display("watchdog and reset test done");
    conclude();
  end
endmodule // etc_timer_tb
